// file: pkg/dioc_defines.vh
// Constants for the double-rate capable I/O cell: register map,
// field positions, reset values and clock source codes.
// Assumes inclusion by bare name from the design file.
`ifndef DIOC_DEFINES_VH
`define DIOC_DEFINES_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DIOC_ADDR_W        4
`define DIOC_CTRL_ADDR     4'h0
`define DIOC_STATUS_ADDR   4'h4
`define DIOC_INFO_ADDR     4'h8

// ----------------------------------------
// Control fields
// ----------------------------------------
`define DIOC_CTRL_DDR      0
`define DIOC_CTRL_LATCH    1
`define DIOC_CTRL_SEL_LO   2
`define DIOC_CTRL_SEL_HI   3
`define DIOC_CTRL_INV      4
`define DIOC_CTRL_DIFF     5
`define DIOC_CTRL_TAP_LO   6
`define DIOC_CTRL_TAP_HI   7
`define DIOC_CTRL_W        8
`define DIOC_CTRL_RST      8'h00
`define DIOC_DRIVE_RST     4'h3
`define DIOC_TRI_RST       2'h3

// ----------------------------------------
// Status fields
// ----------------------------------------
`define DIOC_ST_OVF        0
`define DIOC_ST_FULL       1
`define DIOC_ST_EMPTY      2
`define DIOC_ST_CLK        3
`define DIOC_ST_LVDS       4

// ----------------------------------------
// Clock source codes
// ----------------------------------------
`define DIOC_SRC_ROUTE     2'h0
`define DIOC_SRC_EDGE1     2'h1
`define DIOC_SRC_EDGE2     2'h2
`define DIOC_SRC_STROBE    2'h3

// ----------------------------------------
// Geometry
// ----------------------------------------
`define DIOC_GROUP_LR      8'h10
`define DIOC_GROUP_TB      8'h12
`define DIOC_SLOTS         2
`define DIOC_TAPS          4

`endif

// file: design/dioc_cell.v
// Programmable I/O cell with two slots, single or double rate output
// and tristate registers, strobe capture of pad input into a FIFO.
// Assumes one 25 MHz clock; all clock sources and pads arrive
// asynchronously and are sampled; software uses a plain register port.
//
// Summary of operation
// - One cell holds two I/O slots, each with its own pad.
// - Each slot drives data and tristate control, and samples its pad.
// - Tristate control is registered: one SDR register plus a DDR latch.
// - In SDR the first tristate input passes one flop or latch element.
// - In DDR both tristate inputs are captured on the rising edge.
// - In DDR the registered second input is latched in the next phase.
// - A mux on the same clock picks which stored value drives the pad.
// - Capture clock is routing, edge clock one, edge clock two or strobe.
// - The selected clock can optionally be inverted.
// - Data groups are 16 slots on left/right, 18 on top/bottom edges.
// - One slot per group holds a delay element building the strobe.
// - The delayed strobe feeds a bus reaching every slot of the group.
// - Memory sends strobe with read data; strobe captures it into inputs.
// - Two neighbouring slots pair as one true and complement pin.
// - Every pair can receive differentially; some pairs drive LVDS out.
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`include "dioc_defines.vh"

// ----------------------------------------
// FIFO with registered output stage
// ----------------------------------------
module dioc_fifo #(
	parameter WIDTH = 4,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_i,
	input  wire             rst_n_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	output reg              out_valid_o,
	input  wire             out_ready_i,
	output reg  [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	wire            push;
	wire            pop;

	assign in_ready_o = (count_reg != DEPTH[AW:0]);
	assign push       = in_valid_i & in_ready_o;
	assign pop        = (count_reg != {(AW+1){1'b0}}) & (~out_valid_o | out_ready_i);

	function [AW-1:0] ptr_inc;
		input [AW-1:0] p;
		begin
			if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1})
				ptr_inc = {AW{1'b0}};
			else
				ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
		end
	endfunction

	always @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data_i;
	end

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr_reg  <= {AW{1'b0}};
			rd_ptr_reg  <= {AW{1'b0}};
			count_reg   <= {(AW+1){1'b0}};
			out_valid_o <= 1'b0;
			out_data_o  <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			if (pop)
			begin
				rd_ptr_reg  <= ptr_inc(rd_ptr_reg);
				out_data_o  <= mem[rd_ptr_reg];
				out_valid_o <= 1'b1;
			end
			else if (out_ready_i)
				out_valid_o <= 1'b0;
			if (push & ~pop)
				count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
			else if (pop & ~push)
				count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
		end
	end
endmodule // dioc_fifo

// ----------------------------------------
// Cell top
// ----------------------------------------
module dioc_cell #(
	parameter EDGE_TB    = 0,
	parameter LVDS_OUT   = 1,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW    = 4
) (
	input  wire                     mclk_i,
	input  wire                     reset_n_i,
	// Register port
	input  wire [`DIOC_ADDR_W-1:0]  reg_addr_i,
	input  wire [31:0]              reg_wdata_i,
	input  wire                     reg_wr_i,
	input  wire                     reg_rd_i,
	output reg  [31:0]              reg_rdata_o,
	// Clock sources
	input  wire                     route_clock_i,
	input  wire                     edge_clock_one_i,
	input  wire                     edge_clock_two_i,
	input  wire                     strobe_i,
	// Core side, one bit per slot
	input  wire [1:0]               out_data_first_i,
	input  wire [1:0]               out_data_second_i,
	input  wire [1:0]               tristate_core_in_first_i,
	input  wire [1:0]               tristate_core_in_second_i,
	// Pad side
	output reg  [1:0]               pad_out_o,
	output reg  [1:0]               pad_tristate_ctl_o,
	input  wire [1:0]               pad_in_i,
	// Captured input stream
	output wire                     rx_valid_o,
	input  wire                     rx_ready_i,
	output wire [3:0]               rx_data_o
);
	reg  [1:0]              rst_sync_reg;
	wire                    rst_n;
	reg  [5:0]              sync1_reg;
	reg  [5:0]              sync2_reg;
	reg  [`DIOC_TAPS-1:0]   tap_reg;
	reg  [`DIOC_CTRL_W-1:0] ctrl_reg;
	reg                     ovf_reg;
	reg                     clk_prev_reg;
	reg  [3:0]              pos_first_reg;
	reg  [3:0]              pos_second_reg;
	reg  [3:0]              neg_second_reg;
	reg  [3:0]              sdr_reg;
	reg  [1:0]              cap_rise_reg;
	reg                     push_reg;
	reg  [3:0]              push_data_reg;
	reg  [3:0]              drive_next;
	reg  [1:0]              pad_out_next;
	reg  [1:0]              tri_next;
	reg  [31:0]             rdata_next;
	reg                     clk_src;
	wire                    ddr_mode;
	wire                    diff_on;
	wire                    sel_clk;
	wire                    rise;
	wire                    fall;
	wire [1:0]              pad_now;
	wire [3:0]              src_first;
	wire [3:0]              src_second;
	wire                    fifo_ready;
	wire                    fifo_out_valid;
	wire [3:0]              fifo_out_data;
	wire [7:0]              group_w;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// ----------------------------------------
	// Input sampling
	// ----------------------------------------
	// Clocks and pads all come from foreign domains
	always @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_reg <= 6'h00;
			sync2_reg <= 6'h00;
		end
		else
		begin
			sync1_reg <= {pad_in_i, strobe_i, edge_clock_two_i,
				edge_clock_one_i, route_clock_i};
			sync2_reg <= sync1_reg;
		end
	end

	// strobe delay element
	// Tap granularity is one system clock; a coarse stand-in for fine delay
	always @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
			tap_reg <= {`DIOC_TAPS{1'b0}};
		else
			tap_reg <= {tap_reg[`DIOC_TAPS-2:0], sync2_reg[3]};
	end

	assign group_w = (EDGE_TB != 0) ? `DIOC_GROUP_TB : `DIOC_GROUP_LR;

	// ----------------------------------------
	// Clock selection
	// ----------------------------------------
	// four clock sources
	always @*
	begin
		case (ctrl_reg[`DIOC_CTRL_SEL_HI:`DIOC_CTRL_SEL_LO])
			`DIOC_SRC_ROUTE:  clk_src = sync2_reg[0];
			`DIOC_SRC_EDGE1:  clk_src = sync2_reg[1];
			`DIOC_SRC_EDGE2:  clk_src = sync2_reg[2];
			`DIOC_SRC_STROBE: clk_src = tap_reg[ctrl_reg[`DIOC_CTRL_TAP_HI:`DIOC_CTRL_TAP_LO]];
			default:          clk_src = sync2_reg[0];
		endcase
	end

	assign sel_clk = clk_src ^ ctrl_reg[`DIOC_CTRL_INV];
	assign rise    = sel_clk & ~clk_prev_reg;
	assign fall    = ~sel_clk & clk_prev_reg;

	assign ddr_mode = ctrl_reg[`DIOC_CTRL_DDR];
	// differential output only where driver exists
	assign diff_on  = ctrl_reg[`DIOC_CTRL_DIFF] & (LVDS_OUT != 0);

	// Bits 3:2 data per slot, bits 1:0 tristate per slot
	assign src_first  = {out_data_first_i, tristate_core_in_first_i};
	assign src_second = {out_data_second_i, tristate_core_in_second_i};

	// ----------------------------------------
	// Output and tristate registers
	// ----------------------------------------
	always @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clk_prev_reg   <= 1'b0;
			pos_first_reg  <= `DIOC_DRIVE_RST;
			pos_second_reg <= `DIOC_DRIVE_RST;
			neg_second_reg <= `DIOC_DRIVE_RST;
			sdr_reg        <= `DIOC_DRIVE_RST;
		end
		else
		begin
			clk_prev_reg <= sel_clk;
			if (rise)
			begin
				pos_first_reg  <= src_first;
				pos_second_reg <= src_second;
			end
			// second value held in low phase
			if (fall)
				neg_second_reg <= pos_second_reg;
			if (ctrl_reg[`DIOC_CTRL_LATCH] ? sel_clk : rise)
				sdr_reg <= src_first;
		end
	end

	always @*
	begin
		// high phase first, low phase second
		if (ddr_mode)
			drive_next = sel_clk ? pos_first_reg : neg_second_reg;
		else
			drive_next = sdr_reg;
		pad_out_next = drive_next[3:2];
		tri_next     = drive_next[1:0];
		// slot one becomes the complement pin
		if (diff_on)
		begin
			pad_out_next[1] = ~drive_next[2];
			tri_next[1]     = drive_next[0];
		end
	end

	// drive pads, one pair per slot
	always @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pad_out_o          <= 2'b00;
			pad_tristate_ctl_o <= `DIOC_TRI_RST;
		end
		else
		begin
			pad_out_o          <= pad_out_next;
			pad_tristate_ctl_o <= tri_next;
		end
	end

	// ----------------------------------------
	// Input capture
	// ----------------------------------------
	// differential input always uses the true pin
	assign pad_now = ctrl_reg[`DIOC_CTRL_DIFF] ? {2{sync2_reg[4]}} : sync2_reg[5:4];

	always @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cap_rise_reg  <= 2'b00;
			push_reg      <= 1'b0;
			push_data_reg <= 4'h0;
		end
		else
		begin
			push_reg <= 1'b0;
			if (rise)
				cap_rise_reg <= pad_now;
			if (ddr_mode & fall)
			begin
				push_reg      <= 1'b1;
				push_data_reg <= {cap_rise_reg, pad_now};
			end
			else if (~ddr_mode & rise)
			begin
				push_reg      <= 1'b1;
				push_data_reg <= {2'b00, pad_now};
			end
		end
	end

	dioc_fifo #(
		.WIDTH (4),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk_i       (mclk_i),
		.rst_n_i     (rst_n),
		.in_valid_i  (push_reg),
		.in_ready_o  (fifo_ready),
		.in_data_i   (push_data_reg),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (rx_ready_i),
		.out_data_o  (fifo_out_data)
	);
	assign rx_valid_o = fifo_out_valid;
	assign rx_data_o  = fifo_out_data;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always @*
	begin
		rdata_next = 32'h0000_0000;
		case (reg_addr_i)
			`DIOC_CTRL_ADDR:
				rdata_next[`DIOC_CTRL_W-1:0] = ctrl_reg;
			`DIOC_STATUS_ADDR:
			begin
				rdata_next[`DIOC_ST_OVF]   = ovf_reg;
				rdata_next[`DIOC_ST_FULL]  = ~fifo_ready;
				rdata_next[`DIOC_ST_EMPTY] = ~fifo_out_valid;
				rdata_next[`DIOC_ST_CLK]   = sel_clk;
				rdata_next[`DIOC_ST_LVDS]  = (LVDS_OUT != 0);
			end
			`DIOC_INFO_ADDR:
				rdata_next[7:0] = group_w;
			default:
				rdata_next = 32'h0000_0000;
		endcase
	end

	always @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_reg    <= `DIOC_CTRL_RST;
			ovf_reg     <= 1'b0;
			reg_rdata_o <= 32'h0000_0000;
		end
		else
		begin
			if (reg_wr_i && reg_addr_i == `DIOC_CTRL_ADDR)
				ctrl_reg <= reg_wdata_i[`DIOC_CTRL_W-1:0];
			// Lost capture sets overflow; set wins over write-one clear
			if (push_reg & ~fifo_ready)
				ovf_reg <= 1'b1;
			else if (reg_wr_i && reg_addr_i == `DIOC_STATUS_ADDR
				&& reg_wdata_i[`DIOC_ST_OVF])
				ovf_reg <= 1'b0;
			reg_rdata_o <= reg_rd_i ? rdata_next : 32'h0000_0000;
		end
	end
endmodule // dioc_cell

// file: testbench/dioc_cell_props.sv
// Port checker of the I/O cell: register port, pads and stream.
// Bound into dioc_cell; keeps its own copy of the control register.
`timescale 1ns/1ps
module dioc_cell_props #(
	parameter EDGE_TB  = 0,
	parameter LVDS_OUT = 1
) (
	input wire logic        mclk_i,
	input wire logic        reset_n_i,
	input wire logic [3:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        route_clock_i,
	input wire logic        edge_clock_one_i,
	input wire logic        edge_clock_two_i,
	input wire logic        strobe_i,
	input wire logic [1:0]  tristate_core_in_first_i,
	input wire logic [1:0]  pad_out_o,
	input wire logic [1:0]  pad_tristate_ctl_o,
	input wire logic        rx_valid_o
);
	logic [7:0] c;
	logic [3:0] q;
	logic [3:0] s;
	logic       e;
	wire  [3:0] n  = {route_clock_i, edge_clock_one_i, edge_clock_two_i, strobe_i};
	wire  [1:0] k  = 2'h3 - c[3:2];
	wire        sl = n[k] ^ c[4];
	wire        wc = reg_wr_i && reg_addr_i == 4'h0;
	wire        rs = reg_rd_i && reg_addr_i == 4'h4;
	// Quiet count covers sync and the longest strobe tap
	always_ff @(posedge mclk_i or negedge reset_n_i)
		if (!reset_n_i)
		begin
			c <= 8'h00;
			q <= 4'h0;
			s <= 4'h0;
			e <= 1'b0;
		end
		else
		begin
			if (wc)
				c <= reg_wdata_i[7:0];
			q <= (s != n || wc) ? 4'h0 : q + {3'h0, q != 4'hf};
			e <= wc ? 1'b0 : (e || s[k] != n[k]);
			s <= n;
		end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	a_info_width: assert property (
		reg_rd_i && reg_addr_i == 4'h8 |=> reg_rdata_o == (EDGE_TB ? 32'h12 : 32'h10))
		else $error("group width read wrong");
	a_lvds_flag: assert property (
		rs |=> reg_rdata_o[4] == (LVDS_OUT != 0)) else $error("lvds flag wrong");
	a_ctrl_mirror: assert property (
		reg_rd_i && reg_addr_i == 4'h0 |=> reg_rdata_o[7:0] == $past(c))
		else $error("control readback wrong");
	a_clk_level: assert property (
		rs && q > 4'h9 |=> reg_rdata_o[3] == $past(sl)) else $error("clock level wrong");
	a_pad_quiet: assert property (
		q > 4'h9 && !c[1] |-> $stable(pad_out_o) && $stable(pad_tristate_ctl_o))
		else $error("pad moved without clock");
	a_latch_follow: assert property (
		!c[0] && c[1] && !c[5] && q > 4'h9 && sl && $stable(tristate_core_in_first_i)
		|=> pad_tristate_ctl_o == $past(tristate_core_in_first_i)) else $error("latch stuck");
	a_diff_pair: assert property (
		c[5] && e && q > 4'h9 && LVDS_OUT != 0 |-> pad_out_o[1] != pad_out_o[0]
		&& pad_tristate_ctl_o[1] == pad_tristate_ctl_o[0]) else $error("pair not paired");
	a_empty_flag: assert property (
		rs |=> reg_rdata_o[2] == !$past(rx_valid_o)) else $error("empty flag wrong");
endmodule // dioc_cell_props

bind dioc_cell dioc_cell_props #(.EDGE_TB(EDGE_TB), .LVDS_OUT(LVDS_OUT))
	u_dioc_cell_props (.*);

// file: testbench/dioc_mem_model.sv
// Far-side memory: read data with an edge-aligned strobe, 320 ns period.
// Assumes the bench pulses go_i and waits on busy_o; even beat count.
`timescale 1ns/1ps
module dioc_mem_model (
	input  wire logic       go_i,
	input  wire logic [5:0] beats_i,
	output logic            strobe_o,
	output logic [1:0]      pad_o,
	output logic            busy_o
);
	// One process owns every output, so each line has a single driver
	initial
	begin
		strobe_o = 1'b0;
		pad_o    = 2'h2;
		busy_o   = 1'b0;
		forever
		begin
			@(posedge go_i);
			busy_o = 1'b1;
			#7;
			for (int b = 0; b < beats_i; b++)
			begin
				pad_o    = 2'(3 * b + 1);
				strobe_o = ~strobe_o;
				#160;
			end
			// Released lines are driven to the inverse of the last beat's data
			pad_o  = ~pad_o;
			busy_o = 1'b0;
		end
	end
endmodule // dioc_mem_model

// file: testbench/dioc_cell_bench.sv
// Bench of the I/O cell: register tasks, pad scenarios, strobe burst.
// Assumes dioc_cell, its checker and the memory model are compiled.
`timescale 1ns/1ps
module dioc_cell_bench;
	logic        mclk_i;
	logic        reset_n_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic        rx_ready_i;
	logic        go;
	logic [3:0]  reg_addr_i;
	logic [3:0]  srcs;
	logic [31:0] reg_wdata_i;
	logic [1:0]  first, second, tfirst, tsecond;
	wire  [31:0] reg_rdata_o;
	wire  [1:0]  pad_out, pad_tz, pad_in;
	wire  [3:0]  rx_data;
	wire         rx_valid, mem_strb, busy;
	logic [3:0]  rxq[$];
	int          fails, comparisons, k;
	dioc_cell u_dioc_cell (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .route_clock_i(srcs[3]), .edge_clock_one_i(srcs[2]),
		.edge_clock_two_i(srcs[1]), .strobe_i(srcs[0] ^ mem_strb), .out_data_first_i(first),
		.out_data_second_i(second), .tristate_core_in_first_i(tfirst),
		.tristate_core_in_second_i(tsecond), .pad_out_o(pad_out), .pad_tristate_ctl_o(pad_tz),
		.pad_in_i(pad_in), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data));
	dioc_mem_model u_dioc_mem_model (.go_i(go), .beats_i(6'h28), .strobe_o(mem_strb),
		.pad_o(pad_in), .busy_o(busy));
	task cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		@(negedge mclk_i);
		chk(reg_rdata_o & m, x);
		@(posedge mclk_i);
	endtask
	task pads(input logic [3:0] x);
		chk({28'h0, pad_out, pad_tz}, {28'h0, x});
	endtask
	task set_src(input logic [3:0] m, input int n);
		srcs <= m;
		cyc(n);
	endtask
	function automatic logic [1:0] bv(input int b);
		return 2'(3 * b + 1);
	endfunction
	task finish_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge mclk_i)
		if (rx_valid && rx_ready_i)
			rxq.push_back(rx_data);
	initial
	begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	initial
	begin
		#400000;
		fails++;
		finish_test;
	end
	initial
	begin
		{reset_n_i, reg_wr_i, reg_rd_i, go, srcs, reg_addr_i} = '0;
		{first, second, tfirst, tsecond, reg_wdata_i} = '0;
		rx_ready_i  = 1'b1;
		fails       = 0;
		comparisons = 0;
		cyc(4);
		reset_n_i <= 1'b1;
		cyc(3);
		pads(4'h3);
		rdc(4'h0, 32'hffffffff, 32'h0);
		rdc(4'h8, 32'hffffffff, 32'h10);
		rdc(4'h4, 32'h1c, 32'h14);
		wr(4'hc, 32'hff);
		rdc(4'hc, 32'hffffffff, 32'h0);
		wr(4'h0, 32'hffffffa5);
		rdc(4'h0, 32'hffffffff, 32'ha5);
		$display("register test done");
		for (int s = 0; s < 4; s++)
			for (int i = 0; i < 2; i++)
			begin
				wr(4'h0, 32'(s * 4 + i * 208));
				set_src(4'h8 >> s, 12);
				rdc(4'h4, 32'h8, 32'(i == 0) << 3);
				set_src(~(4'h8 >> s), 12);
				rdc(4'h4, 32'h8, 32'(i) << 3);
			end
		set_src(4'h0, 12);
		$display("clock source test done");
		wr(4'h0, 32'h0);
		{first, tfirst} <= 4'h9;
		set_src(4'h8, 12);
		pads(4'h9);
		{first, tfirst} <= 4'h6;
		cyc(12);
		pads(4'h9);
		wr(4'h0, 32'h2);
		cyc(12);
		chk(32'(pad_tz), 32'h2);
		tfirst <= 2'h1;
		cyc(4);
		chk(32'(pad_tz), 32'h1);
		wr(4'h0, 32'h20);
		{first, tfirst} <= 4'hd;
		set_src(4'h0, 12);
		set_src(4'h8, 12);
		pads(4'h7);
		$display("single rate test done");
		wr(4'h0, 32'h1);
		{first, second, tfirst, tsecond} <= 8'h93;
		set_src(4'h0, 12);
		set_src(4'h8, 12);
		pads(4'h8);
		{first, second, tfirst, tsecond} <= 8'h6c;
		set_src(4'h0, 12);
		pads(4'h7);
		$display("double rate test done");
		wr(4'h0, 32'hd);
		cyc(30);
		rx_ready_i <= 1'b0;
		cyc(1);
		rxq.delete();
		go <= 1'b1;
		cyc(1);
		go <= 1'b0;
		k = 0;
		while (busy && k < 400)
		begin
			cyc(1);
			k++;
		end
		chk(32'(busy), 32'h0);
		cyc(12);
		rdc(4'h4, 32'h7, 32'h3);
		rx_ready_i <= 1'b1;
		cyc(40);
		chk(rxq.size(), 32'h11);
		for (int j = 0; j < 17; j++)
			chk(32'(rxq[j]), 32'({bv(2 * j), bv(2 * j + 1)}));
		rdc(4'h4, 32'h7, 32'h5);
		wr(4'h4, 32'h1);
		rdc(4'h4, 32'h7, 32'h4);
		$display("strobe capture test done");
		finish_test;
	end
endmodule // dioc_cell_bench
